// *** core/acc_core.sv ***
// Converter control block: APB registers, clock divider, SAR sequencer
//
// What this block does
// - Start pulse low-high-low launches one conversion
// - Pending flag falls when conversion finishes
// - Result readable as low and high registers
// - Conversion lasts sixteen converter clock periods
// - Result is twelve bits, all ones full-scale
// - Code step is reference over 4096, offset
// - Power-down bit stops converter activity
// - Divider codes select system clock ratios
// - Analog pin drops other functions and pull-high
// - Interrupt needs global, multi-function, converter enables
// - Completion sets converter interrupt request flag
// - Start held high resets converter, sets pending
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ns
module acc_core
    import acc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [acc_pkg::ADDR_W-1:0] paddr,
    input wire logic [acc_pkg::DATA_W-1:0] pwdata,
    output logic pready,
    output logic [acc_pkg::DATA_W-1:0] prdata,
    output logic pslverr,
    // Analog front end
    input wire logic compAbove,
    output logic [acc_pkg::RES_W-1:0] dacCode,
    output logic [acc_pkg::CH_W-1:0] channelSelect,
    output logic converterPowerDown,
    output logic convReset,
    output logic sampleOn,
    output logic adcClkTick,
    // Shared pins
    input wire logic [7:0] pullReq,
    output logic [7:0] analogPinEnable,
    output logic [7:0] pullHighOn,
    // Interrupt
    output logic irq
);

    // All state of the block
    typedef struct packed {
        acc_state_t st;
        logic [CH_W-1:0] chan;
        logic startBit;
        logic pend;
        logic [DIV_W-1:0] divSel;
        logic pwrDown;
        logic [7:0] pinEn;
        logic [2:0] intEn;
        logic irqFlag;
        logic irqMask;
        logic [4:0] divCnt;
        logic tick;
        logic [3:0] tadCnt;
        logic [RES_W-1:0] trial;
        logic [3:0] bitIdx;
        logic done;
        logic convRst;
        logic sample;
        logic [7:0] pullOn;
        logic irq;
        logic pready;
        logic [DATA_W-1:0] prdata;
        logic pslverr;
    } acc_core_t;

    acc_core_t s_reg;
    acc_core_t s_next;

    // Read data of the result store
    logic [7:0] resRd;
    // Per-pin pull-high gating
    logic [7:0] pullGate;
    // Decoded bus terms
    logic access;
    logic mapped;
    logic wrDone;
    logic wrCtrl;
    logic launch;

    // Divider terminal count for each select code
    function automatic logic [4:0] term_count(input logic [DIV_W-1:0] sel);
        logic [4:0] tc;
        tc = TC_32;
        // Codes with no defined ratio fall back to the slowest clock
        case (sel)
            DIV_1: tc = TC_1;
            DIV_2: tc = TC_2;
            DIV_4: tc = TC_4;
            DIV_8: tc = TC_8;
            DIV_16: tc = TC_16;
            DIV_32: tc = TC_32;
            default: tc = TC_32;
        endcase
        return tc;
    endfunction

    // Result store, read address taken from the setup cycle
    acc_result_store u_store (
        .clk(clk),
        .rst(rst),
        .wrEn(s_reg.done),
        .wrData(s_reg.trial),
        .rdHigh(paddr == OFS_RESHI),
        .rdData(resRd)
    );

    // Analog pins lose their pull-high resistor
    generate
        for (genvar i = 0; i < 8; i++) begin : g_pin
            assign pullGate[i] = pullReq[i] & ~s_reg.pinEn[i];
        end
    endgenerate

    // Bus decode: a write lands on the edge that sees pready high
    assign access = psel & penable;
    assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_CLK)
        || (paddr == OFS_PIN) || (paddr == OFS_RESLO)
        || (paddr == OFS_RESHI) || (paddr == OFS_INTEN)
        || (paddr == OFS_STAT) || (paddr == OFS_MASK);
    assign wrDone = access & s_reg.pready & pwrite & mapped;
    assign wrCtrl = wrDone & (paddr == OFS_CTRL);
    assign launch = wrCtrl & s_reg.startBit & ~pwdata[START_BIT]
        & (s_reg.st == ST_HELD) & ~s_reg.pwrDown;

    // Next-state logic
    always_comb begin
        logic [3:0] idx;
        idx = '0;
        s_next = s_reg;
        s_next.done = 1'b0;

        // Access phase: one wait cycle, then answer from flops
        if (access && !s_reg.pready) begin
            s_next.pready = 1'b1;
            s_next.pslverr = ~mapped;
            s_next.prdata = '0;
            // Unmapped reads return zero with an error
            case (paddr)
                OFS_CTRL: s_next.prdata = DATA_W'({s_reg.startBit,
                    s_reg.pend, 2'b00, s_reg.chan});
                OFS_CLK: s_next.prdata = DATA_W'({s_reg.pwrDown,
                    4'h0, s_reg.divSel});
                OFS_PIN: s_next.prdata = DATA_W'(s_reg.pinEn);
                OFS_RESLO: s_next.prdata = DATA_W'(resRd);
                OFS_RESHI: s_next.prdata = DATA_W'(resRd);
                OFS_INTEN: s_next.prdata = DATA_W'(s_reg.intEn);
                OFS_STAT: s_next.prdata = DATA_W'(s_reg.irqFlag);
                OFS_MASK: s_next.prdata = DATA_W'(s_reg.irqMask);
                default: s_next.prdata = '0;
            endcase
        end else begin
            s_next.pready = 1'b0;
            s_next.pslverr = 1'b0;
        end

        // Register writes
        if (wrDone) begin
            case (paddr)
                OFS_CTRL: begin
                    s_next.chan = pwdata[CH_LSB +: CH_W];
                    s_next.startBit = pwdata[START_BIT];
                end
                OFS_CLK: begin
                    s_next.divSel = pwdata[DIV_LSB +: DIV_W];
                    s_next.pwrDown = pwdata[PD_BIT];
                end
                OFS_PIN: s_next.pinEn = pwdata[7:0];
                OFS_INTEN: s_next.intEn = {pwdata[CIE_BIT],
                    pwdata[MFE_BIT], pwdata[GIE_BIT]};
                // Write one to clear; a same-cycle completion still wins
                OFS_STAT: if (pwdata[IRQ_BIT]) begin
                    s_next.irqFlag = 1'b0;
                end
                OFS_MASK: s_next.irqMask = pwdata[IRQ_BIT];
                default: s_next.irqMask = s_reg.irqMask;
            endcase
        end

        // Converter clock divider
        if (s_reg.divCnt >= term_count(s_reg.divSel)) begin
            s_next.tick = 1'b1;
            s_next.divCnt = '0;
        end else begin
            s_next.tick = 1'b0;
            s_next.divCnt = s_reg.divCnt + 5'h01;
        end

        // Start bit edges drive the sequencer
        if (wrCtrl && !s_reg.startBit && pwdata[START_BIT]) begin
            // Rising edge holds the converter in reset
            s_next.st = ST_HELD;
            s_next.pend = 1'b1;
        end else if (launch) begin
            // Falling edge after the rise begins a conversion
            s_next.st = ST_CONV;
            s_next.tadCnt = '0;
            s_next.trial = '0;
            s_next.divCnt = '0;
            s_next.tick = 1'b0;
        end else begin
            // Successive approximation, one step per converter clock
            case (s_reg.st)
                ST_IDLE: s_next.st = ST_IDLE;
                ST_HELD: s_next.st = ST_HELD;
                ST_CONV: if (s_reg.tick) begin
                    s_next.tadCnt = s_reg.tadCnt + 4'h1;
                    // Comparator answers the code set one step earlier
                    if (s_reg.tadCnt > SET_TAD && !compAbove) begin
                        s_next.trial[s_reg.bitIdx] = 1'b0;
                    end
                    // Try the next lower bit
                    if (s_reg.tadCnt >= SET_TAD && s_reg.tadCnt != LAST_TAD) begin
                        idx = (s_reg.tadCnt == SET_TAD) ? MSB_IDX
                            : s_reg.bitIdx - 4'h1;
                        s_next.trial[idx] = 1'b1;
                        s_next.bitIdx = idx;
                    end
                    // Sixteenth period closes the conversion
                    if (s_reg.tadCnt == LAST_TAD) begin
                        s_next.st = ST_IDLE;
                        s_next.done = 1'b1;
                        s_next.pend = 1'b0;
                        s_next.irqFlag = 1'b1;
                    end
                end
                default: s_next.st = ST_IDLE;
            endcase
        end

        // Powered down converter is held idle; the divider keeps ticking
        if (s_next.pwrDown) begin
            s_next.st = ST_IDLE;
        end

        // Registered views for the analog side and pins
        s_next.convRst = (s_next.st == ST_HELD);
        s_next.sample = (s_next.st == ST_CONV) && (s_next.tadCnt < SET_TAD);
        s_next.pullOn = pullGate;
        // All three enables and the mask gate the request
        s_next.irq = s_reg.irqFlag & s_reg.irqMask & (&s_reg.intEn);
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_reg <= '{st: ST_IDLE, divSel: DIV_RST, pwrDown: PD_RST,
                default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register
    assign pready = s_reg.pready;
    assign prdata = s_reg.prdata;
    assign pslverr = s_reg.pslverr;
    assign dacCode = s_reg.trial;
    assign channelSelect = s_reg.chan;
    assign converterPowerDown = s_reg.pwrDown;
    assign convReset = s_reg.convRst;
    assign sampleOn = s_reg.sample;
    assign adcClkTick = s_reg.tick;
    assign analogPinEnable = s_reg.pinEn;
    assign pullHighOn = s_reg.pullOn;
    assign irq = s_reg.irq;

    // Checks on the sequencer and register side effects
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Rising start write while powered
    sequence sStartRise;
        wrCtrl && !s_reg.startBit && pwdata[START_BIT] && !s_reg.pwrDown;
    endsequence

    // Four-way divider running undisturbed for three cycles
    sequence sDiv4Run;
        (s_reg.tick && s_reg.divSel == DIV_4 && !launch)
        ##1 (s_reg.divSel == DIV_4 && !launch)[*3];
    endsequence

    a_start_launch: assert property (launch |=> s_reg.st == ST_CONV)
        else $error("Start pulse did not launch a conversion");

    a_held_pend: assert property (sStartRise |=> s_reg.pend ##1 convReset)
        else $error("Held start did not reset converter");

    a_done_pend: assert property (s_reg.done |-> !s_reg.pend)
        else $error("Pending flag high after completion");

    a_done_flag: assert property (s_reg.done |-> s_reg.irqFlag)
        else $error("Completion did not raise request flag");

    a_conv_len: assert property (s_reg.done |->
        $past(s_reg.tadCnt) == LAST_TAD && $past(s_reg.tick))
        else $error("Conversion did not end on sixteenth period");

    a_irq_gate: assert property (irq |->
        $past(s_reg.irqFlag && s_reg.irqMask && (&s_reg.intEn)))
        else $error("Interrupt without all enables");

    a_pwr_idle: assert property (s_reg.pwrDown |-> s_reg.st == ST_IDLE)
        else $error("Converter active while powered down");

    a_pin_pull: assert property ((pullHighOn & $past(s_reg.pinEn)) == 8'h00)
        else $error("Pull-high left on an analog pin");

    a_div_ratio: assert property (sDiv4Run |=> s_reg.tick)
        else $error("Divide-by-four tick spacing wrong");

    // Bus answer and error stand one cycle only
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("Ready held for more than one cycle");

    a_err_ready: assert property (pslverr |-> pready)
        else $error("Error flagged outside a bus answer");

    a_reset_pend: assert property (convReset |-> s_reg.pend)
        else $error("Converter held in reset without pending flag");

    a_conv_pend: assert property (s_reg.st == ST_CONV |-> s_reg.pend)
        else $error("Pending flag low during a conversion");

    a_launch_clear: assert property (launch |=> dacCode == '0 && !adcClkTick)
        else $error("Launch did not clear the trial code");

    // Completion seen with mask and all three enables open
    sequence sDoneOpen;
        s_reg.done && s_reg.irqMask && (&s_reg.intEn);
    endsequence

    a_irq_raise: assert property (sDoneOpen |=> irq)
        else $error("Enabled completion did not raise the interrupt");

endmodule

// *** core/acc_result_store.sv ***
// Result store holding the last completed conversion value
`timescale 1ns/1ns
module acc_result_store
    import acc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Write side
    input wire logic wrEn,
    input wire logic [acc_pkg::RES_W-1:0] wrData,
    // Read side
    input wire logic rdHigh,
    output logic [7:0] rdData
);

    // All state of the store
    typedef struct packed {
        logic [RES_W-1:0] value;
        logic [7:0] rd;
    } acc_store_t;

    acc_store_t s_reg;
    acc_store_t s_next;

    // Next value: write on completion, read data always registered
    always_comb begin
        s_next = s_reg;
        // Value only moves when a conversion completes
        if (wrEn) begin
            s_next.value = wrData;
        end
        // High part sits in the low nibble, upper bits read zero
        if (rdHigh) begin
            s_next.rd = {4'h0, s_reg.value[RES_W-1:8]};
        end else begin
            s_next.rd = s_reg.value[7:0];
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rdData = s_reg.rd;

    // Stored value never drifts between completions
    a_hold_value: assert property (@(posedge clk) disable iff (rst)
        !wrEn |=> $stable(s_reg.value))
        else $error("Result changed without a completion");

endmodule

// *** dv/test_adc_conversion_control.sv ***
// Self-checking bench for the converter control block
`timescale 1ns/1ns
module test_adc_conversion_control;
    import acc_pkg::*;
    // Outcome of one APB transfer, noted by the driver
    typedef struct {logic [31:0] d; logic w; logic e;} acc_note_t;
    // Design inputs
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic compAbove = 1'b0;
    logic [7:0] pullReq = 8'h00;
    // Design outputs
    logic pready;
    logic pslverr;
    logic irq;
    logic converterPowerDown;
    logic convReset;
    logic sampleOn;
    logic adcClkTick;
    logic [31:0] prdata;
    logic [11:0] dacCode;
    logic [3:0] channelSelect;
    logic [7:0] analogPinEnable;
    logic [7:0] pullHighOn;
    // Bench state
    acc_note_t notes[$];
    int errTotal = 0;
    int nTests = 0;
    int seed = 92654;
    int cyc = 0;
    int vin2 = 0; // Analog input in half-step units
    logic [11:0] lastRes = 12'h000;

    acc_core u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .compAbove(compAbove), .dacCode(dacCode), .channelSelect(channelSelect),
        .converterPowerDown(converterPowerDown), .convReset(convReset), .sampleOn(sampleOn),
        .adcClkTick(adcClkTick), .pullReq(pullReq), .analogPinEnable(analogPinEnable),
        .pullHighOn(pullHighOn), .irq(irq));

    // 20 MHz system clock
    always #25 clk = ~clk;

    // Cycle count, updated late so readers at an edge see the old count
    always @(posedge clk) begin
        cyc <= cyc + 1;
    end

    // Comparator follows each new trial code in the edge's own time step,
    // so even the undivided converter clock sees a settled answer
    always @(dacCode or vin2) begin
        compAbove <= (vin2 >= 2 * int'(dacCode) - 1);
    end

    // Compare one value, count it, report a mismatch at once
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            errTotal++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Final verdict, the one place where the run ends
    task automatic reportAndStop();
        $display("checks %0d mismatches %0d", nTests, errTotal);
        if (errTotal == 0 && nTests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Monitor: each completed transfer takes the oldest note
    always @(posedge clk) begin
        if (pready === 1'b1 && notes.size() > 0) begin
            if (!notes[0].w) begin
                check("prdata", prdata, notes[0].d);
            end
            check("pslverr", 32'(pslverr), 32'(notes[0].e));
            void'(notes.pop_front());
        end
    end

    // One APB transfer; holds the request until pready is sampled high
    task automatic apbXfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                           input logic [31:0] ex, input logic err);
        notes.push_back('{d: ex, w: w, e: err});
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // No cycle count assumed; only the watchdog ends a missing answer
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Wait for one divided clock tick, bounded
    task automatic waitTick();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (adcClkTick !== 1'b1 && n < 100);
    endtask

    // Low-high-low pulse on the start bit, start bit cleared beforehand
    task automatic startPulse(input logic [3:0] ch);
        apbXfer(1'b1, OFS_CTRL, {28'h0, ch}, 32'h0, 1'b0);
        apbXfer(1'b1, OFS_CTRL, {24'h0, 4'h8, ch}, 32'h0, 1'b0);
        repeat (2) @(posedge clk);
        check("held reset", 32'(convReset), 32'h0000_0001);
        check("channel out", 32'(channelSelect), 32'(ch));
        apbXfer(1'b0, OFS_CTRL, 32'h0, {24'h0, 4'hC, ch}, 1'b0);
        apbXfer(1'b1, OFS_CTRL, {28'h0, ch}, 32'h0, 1'b0);
    endtask

    // Full conversion at one divider setting with a random input
    task automatic runConv(input logic [2:0] code, input int r);
        int t0;
        int t1;
        int n;
        int c;
        logic [3:0] ch;
        ch = 4'($random(seed));
        vin2 = $random(seed) & 32'h0000_1FFF;
        c = (vin2 + 1) / 2;
        if (c > 4095) begin
            c = 4095;
        end
        apbXfer(1'b1, OFS_CLK, {29'h0, code}, 32'h0, 1'b0);
        startPulse(ch);
        t0 = cyc;
        waitTick();
        t1 = cyc;
        check("sampling", 32'(sampleOn), 32'h0000_0001);
        waitTick();
        check("tick spacing", 32'(cyc - t1), 32'(r));
        n = 0;
        while (irq !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        check("conversion span", 32'(cyc - t0 >= 16 * r && cyc - t0 <= 17 * r + 4), 1);
        check("dac code", 32'(dacCode), 32'(c));
        check("sample off", 32'(sampleOn), 32'h0);
        lastRes = 12'(c);
        apbXfer(1'b0, OFS_RESLO, 32'h0, {24'h0, lastRes[7:0]}, 1'b0);
        apbXfer(1'b0, OFS_RESHI, 32'h0, {28'h0, lastRes[11:8]}, 1'b0);
        apbXfer(1'b0, OFS_CTRL, 32'h0, {28'h0, ch}, 1'b0);
        apbXfer(1'b0, OFS_STAT, 32'h0, 32'h0000_0001, 1'b0);
        apbXfer(1'b1, OFS_STAT, 32'h0000_0001, 32'h0, 1'b0);
        apbXfer(1'b0, OFS_STAT, 32'h0, 32'h0, 1'b0);
    endtask

    // Hang guard, sized well above the expected run
    initial begin
        #(50 * 40000);
        errTotal++;
        reportAndStop();
    end

    // Main sequence
    initial begin
        logic [2:0] codes [7];
        int ratios [7];
        logic [7:0] p;
        codes = '{DIV_1, DIV_2, DIV_4, DIV_8, DIV_16, DIV_32, 3'h7};
        ratios = '{1, 2, 4, 8, 16, 32, 32};
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check("power down at reset", 32'(converterPowerDown), 32'h0000_0001);
        apbXfer(1'b0, OFS_CLK, 32'h0, 32'h0000_0080, 1'b0);
        apbXfer(1'b0, 8'h20, 32'h0, 32'h0, 1'b1);
        // Analog pins override pull-high requests
        p = 8'($random(seed));
        pullReq <= 8'($random(seed));
        apbXfer(1'b1, OFS_PIN, {24'h0, p}, 32'h0, 1'b0);
        repeat (3) @(posedge clk);
        check("analog pins", 32'(analogPinEnable), 32'(p));
        check("pull high", 32'(pullHighOn), 32'(pullReq & ~p));
        apbXfer(1'b1, OFS_INTEN, 32'h0000_0007, 32'h0, 1'b0);
        apbXfer(1'b1, OFS_MASK, 32'h0000_0001, 32'h0, 1'b0);
        for (int i = 0; i < 7; i++) begin
            runConv(codes[i], ratios[i]);
        end
        // Result low word ignores writes and holds through an aborted run
        apbXfer(1'b1, OFS_RESLO, 32'h0000_00A5, 32'h0, 1'b0);
        startPulse(4'h3);
        repeat (20) @(posedge clk);
        apbXfer(1'b1, OFS_CLK, 32'h0000_0081, 32'h0, 1'b0);
        repeat (2) @(posedge clk);
        check("power down out", 32'(converterPowerDown), 32'h0000_0001);
        repeat (300) @(posedge clk);
        apbXfer(1'b0, OFS_STAT, 32'h0, 32'h0, 1'b0);
        apbXfer(1'b0, OFS_CTRL, 32'h0, 32'h0000_0043, 1'b0);
        apbXfer(1'b0, OFS_RESLO, 32'h0, {24'h0, lastRes[7:0]}, 1'b0);
        // Interrupt gating: flag sets while masked, then enables decide
        apbXfer(1'b1, OFS_MASK, 32'h0, 32'h0, 1'b0);
        apbXfer(1'b1, OFS_CLK, {29'h0, DIV_1}, 32'h0, 1'b0);
        startPulse(4'h1);
        repeat (40) @(posedge clk);
        check("irq masked", 32'(irq), 32'h0);
        apbXfer(1'b0, OFS_CTRL, 32'h0, 32'h0000_0001, 1'b0);
        apbXfer(1'b0, OFS_STAT, 32'h0, 32'h0000_0001, 1'b0);
        apbXfer(1'b1, OFS_MASK, 32'h0000_0001, 32'h0, 1'b0);
        repeat (3) @(posedge clk);
        check("irq unmasked", 32'(irq), 32'h0000_0001);
        apbXfer(1'b1, OFS_INTEN, 32'h0000_0003, 32'h0, 1'b0);
        repeat (3) @(posedge clk);
        check("irq enable off", 32'(irq), 32'h0);
        apbXfer(1'b1, OFS_INTEN, 32'h0000_0006, 32'h0, 1'b0);
        repeat (3) @(posedge clk);
        check("irq global off", 32'(irq), 32'h0);
        apbXfer(1'b1, OFS_INTEN, 32'h0000_0007, 32'h0, 1'b0);
        apbXfer(1'b1, OFS_STAT, 32'h0000_0001, 32'h0, 1'b0);
        repeat (3) @(posedge clk);
        check("irq cleared", 32'(irq), 32'h0);
        repeat (5) @(posedge clk);
        reportAndStop();
    end
endmodule

// *** inc/acc_pkg.sv ***
// Shared constants and types of the converter control block
package acc_pkg;

    // Bus and data widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int RES_W = 12;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CLK = 8'h04;
    localparam logic [7:0] OFS_PIN = 8'h08;
    localparam logic [7:0] OFS_RESLO = 8'h0C;
    localparam logic [7:0] OFS_RESHI = 8'h10;
    localparam logic [7:0] OFS_INTEN = 8'h14;
    localparam logic [7:0] OFS_STAT = 8'h18;
    localparam logic [7:0] OFS_MASK = 8'h1C;

    // Control register fields
    localparam int CH_LSB = 0;
    localparam int CH_W = 4;
    localparam int PEND_BIT = 6;
    localparam int START_BIT = 7;

    // Clock configuration fields
    localparam int DIV_LSB = 0;
    localparam int DIV_W = 3;
    localparam int PD_BIT = 7;

    // Interrupt enable fields, and the flag and mask bit
    localparam int GIE_BIT = 0;
    localparam int MFE_BIT = 1;
    localparam int CIE_BIT = 2;
    localparam int IRQ_BIT = 0;

    // Reset values
    localparam logic [DIV_W-1:0] DIV_RST = 3'h0;
    localparam logic PD_RST = 1'b1;

    // Divider select codes
    localparam logic [DIV_W-1:0] DIV_1 = 3'h4;
    localparam logic [DIV_W-1:0] DIV_2 = 3'h0;
    localparam logic [DIV_W-1:0] DIV_4 = 3'h5;
    localparam logic [DIV_W-1:0] DIV_8 = 3'h1;
    localparam logic [DIV_W-1:0] DIV_16 = 3'h6;
    localparam logic [DIV_W-1:0] DIV_32 = 3'h2;

    // Divider terminal counts (ratio minus one)
    localparam logic [4:0] TC_1 = 5'h00;
    localparam logic [4:0] TC_2 = 5'h01;
    localparam logic [4:0] TC_4 = 5'h03;
    localparam logic [4:0] TC_8 = 5'h07;
    localparam logic [4:0] TC_16 = 5'h0F;
    localparam logic [4:0] TC_32 = 5'h1F;

    // Conversion timing in converter clock periods, top bit index and full-scale code
    localparam logic [3:0] SET_TAD = 4'h3;
    localparam logic [3:0] LAST_TAD = 4'hF;
    localparam logic [3:0] MSB_IDX = 4'hB;
    localparam logic [RES_W-1:0] FULL_SCALE = 12'hFFF;

    // Conversion states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_HELD = 3'b010,
        ST_CONV = 3'b100
    } acc_state_t;

endpackage
